// >>> verilog/nvcs_defs.vh
`ifndef NVCS_DEFS_VH
`define NVCS_DEFS_VH

// ----------------------------------------
// register pointers on the serial port
// ----------------------------------------
`define NVCS_ADDR_GATE_LEVEL 8'h15
`define NVCS_ADDR_STORED_CONFIG 8'h17
`define NVCS_ADDR_STORED_DELAYS 8'h18

// ----------------------------------------
// reset values
// ----------------------------------------
`define NVCS_RST_GATE_LEVEL 6'h16
`define NVCS_RST_STORED 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define NVCS_GATE_MSB 5
`define NVCS_GATE_LSB 0
`define NVCS_CFG_ONCHIP_TEMP 7
`define NVCS_CFG_RELOAD 6
`define NVCS_CFG_SPREAD 5
`define NVCS_CFG_FSW 4
`define NVCS_CFG_RESTART_A_MSB 3
`define NVCS_CFG_RESTART_A_LSB 2
`define NVCS_CFG_RESTART_B_MSB 1
`define NVCS_CFG_RESTART_B_LSB 0
`define NVCS_DLY_T1_MSB 7
`define NVCS_DLY_T1_LSB 6
`define NVCS_DLY_T2_MSB 5
`define NVCS_DLY_T2_LSB 4
`define NVCS_DLY_T3_MSB 3
`define NVCS_DLY_T3_LSB 2
`define NVCS_DLY_COMP 1
`define NVCS_DLY_LEVEL_LSB 0

// ----------------------------------------
// analog decode figures
// ----------------------------------------
`define NVCS_GATE_BASE_MV 15'h15E0
`define NVCS_GATE_STEP_MV 15'h00C8
`define NVCS_FSW_HIGH_KHZ 12'h898
`define NVCS_FSW_LOW_KHZ 12'h1B8

// ----------------------------------------
// timing
// ----------------------------------------
`define NVCS_CLK_KHZ 200000
`define NVCS_GAP_STEP_MS 5
`define NVCS_RELOAD_MS 1000
`define NVCS_GAP_STEP_CYCLES (`NVCS_GAP_STEP_MS * `NVCS_CLK_KHZ)
`define NVCS_RELOAD_CYCLES (`NVCS_RELOAD_MS * `NVCS_CLK_KHZ)

`endif

// >>> verilog/nvcs_sync.v
`timescale 1ns/100ps

// three-flop pin filter; the output moves only when flops two and three agree
module nvcs_sync #(
  parameter [0:0] IDLE_LEVEL = 1'b1
) (
  input wire clk_sys,
  input wire reset,
  input wire pin_in,
  output reg level
);

  reg stage_one;
  reg stage_two;
  reg stage_three;

  // stage_one feeds stage_two only, so metastability never reaches logic
  always @(posedge clk_sys) begin
    if (reset) begin
      stage_one <= IDLE_LEVEL;
      stage_two <= IDLE_LEVEL;
      stage_three <= IDLE_LEVEL;
      level <= IDLE_LEVEL;
    end else begin
      stage_one <= pin_in;
      stage_two <= stage_one;
      stage_three <= stage_two;
      if (stage_two == stage_three) begin
        level <= stage_two;
      end
    end
  end

endmodule

// >>> verilog/nvcs_gap_timer.v
`timescale 1ns/100ps

// waits code times one step, then pulses done for one cycle
module nvcs_gap_timer #(
  parameter [31:0] STEP_CYCLES = 32'h000F4240
) (
  input wire clk_sys,
  input wire reset,
  input wire start,
  input wire [1:0] code,
  output reg done
);

  reg busy;
  reg [1:0] steps_left;
  reg [31:0] cycle_cnt;

  // code zero still costs one cycle so the sequencer sees a clean pulse
  always @(posedge clk_sys) begin
    if (reset) begin
      busy <= 1'b0;
      steps_left <= 2'h0;
      cycle_cnt <= 32'h00000000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        steps_left <= code;
        cycle_cnt <= 32'h00000000;
      end else if (busy) begin
        if (steps_left == 2'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (cycle_cnt == STEP_CYCLES - 32'h00000001) begin
          cycle_cnt <= 32'h00000000;
          steps_left <= steps_left - 2'h1;
        end else begin
          cycle_cnt <= cycle_cnt + 32'h00000001;
        end
      end
    end
  end

endmodule

// >>> verilog/nvcs_regs.v
`timescale 1ns/100ps
`include "nvcs_defs.vh"

// Functional notes
// - six-bit gate code; zero is -5.6 V, minus 0.2 V per step, 0x3F -18.2 V
// - stored config bit 7 set selects the on-chip temperature sensor
// - stored config bit 6 set reloads stored contents into volatile registers each second
// - stored config bit 5 set enables spread spectrum, clear disables it
// - stored config bit 4 selects 2.2 MHz when zero, 440 kHz when one
// - stored config bits 3:2 and 1:0 give fault restart timing codes
// - stored delay bits 7:6 pick start-up gap one of 0, 5, 10, 15 ms
// - stored delay bits 5:4 pick start-up gap two of 0, 5, 10, 15 ms
// - stored delay bits 3:2 pick start-up gap three of 0, 5, 10, 15 ms
// - stored delay bit 1 set enables thermal compensation of the common amplifier
module nvcs_regs #(
  parameter [6:0] DEVICE_ADDR = 7'h2A,
  parameter [31:0] GAP_STEP_CYCLES = `NVCS_GAP_STEP_CYCLES,
  parameter [31:0] RELOAD_CYCLES = `NVCS_RELOAD_CYCLES
) (
  input wire clk_sys,
  input wire reset,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [7:0] stored_config_word,
  input wire [7:0] nv_delay_word,
  input wire [5:0] nv_gate_level_word,
  output reg [5:0] negative_gate_rail,
  output reg [14:0] negative_gate_mv,
  output wire stored_onchip_temp_select,
  output wire stored_periodic_reload,
  output wire stored_spread_enable,
  output wire stored_switch_freq_select,
  output wire [1:0] stored_fault_restart_a,
  output wire [1:0] stored_fault_restart_b,
  output wire [1:0] stored_startup_gap_one,
  output wire [1:0] stored_startup_gap_two,
  output wire [1:0] stored_startup_gap_three,
  output wire stored_thermal_comp_enable,
  output wire stored_common_level_lsb,
  output reg [11:0] switch_freq_khz,
  output reg [2:0] startup_stage_done
);

  // ----------------------------------------
  // serial port states
  // ----------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_PTR = 4'h2;
  localparam [3:0] S_WDATA = 4'h3;
  localparam [3:0] S_ACK_WAIT = 4'h4;
  localparam [3:0] S_ACK_HOLD = 4'h5;
  localparam [3:0] S_RDATA = 4'h6;
  localparam [3:0] S_RACK_WAIT = 4'h7;
  localparam [3:0] S_RACK = 4'h8;
  localparam [3:0] S_RLOAD = 4'h9;

  localparam [1:0] ACK_ADDR = 2'h0;
  localparam [1:0] ACK_PTR = 2'h1;
  localparam [1:0] ACK_DATA = 2'h2;

  localparam [2:0] Q_WAIT = 3'h0;
  localparam [2:0] Q_GAP_ONE = 3'h1;
  localparam [2:0] Q_GAP_TWO = 3'h2;
  localparam [2:0] Q_GAP_THREE = 3'h3;
  localparam [2:0] Q_DONE = 3'h4;

  reg [7:0] stored_config;
  reg [7:0] stored_delays_and_comp;
  reg [5:0] negative_gate_level;
  reg load_pending;
  reg reload_tick;
  reg [31:0] reload_cnt;
  reg [3:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [7:0] ptr;
  reg read_mode;
  reg [1:0] ack_kind;
  reg scl_prev;
  reg sda_prev;
  reg [2:0] seq_state;
  reg gap_start;
  reg [1:0] gap_code;
  reg [7:0] rd_byte;
  wire scl_q;
  wire sda_q;
  wire gap_done;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [7:0] rx_next;
  wire byte_end;
  wire wr_gate_hit;
  wire nv_capture;

  // ----------------------------------------
  // pin filters
  // ----------------------------------------
  nvcs_sync #(
    .IDLE_LEVEL(1'b1)
  ) u_scl_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(scl_in),
    .level(scl_q)
  );

  nvcs_sync #(
    .IDLE_LEVEL(1'b1)
  ) u_sda_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(sda_in),
    .level(sda_q)
  );

  // bus events from filtered levels; start and stop are sda moves while scl is high
  assign scl_rise = scl_q & ~scl_prev;
  assign scl_fall = ~scl_q & scl_prev;
  assign bus_start = scl_q & scl_prev & sda_prev & ~sda_q;
  assign bus_stop = scl_q & scl_prev & ~sda_prev & sda_q;
  assign rx_next = {shift[6:0], sda_q};
  assign byte_end = scl_rise & (bit_cnt == 3'h7);
  // only the volatile gate level accepts data; stored registers have no write path
  assign wr_gate_hit = (state == S_WDATA) & byte_end & (ptr == `NVCS_ADDR_GATE_LEVEL);

  always @(posedge clk_sys) begin
    if (reset) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  // unmapped pointers read zero, reserved gate bits read zero
  always @* begin
    case (ptr)
      `NVCS_ADDR_GATE_LEVEL: rd_byte = {2'h0, negative_gate_level};
      `NVCS_ADDR_STORED_CONFIG: rd_byte = stored_config;
      `NVCS_ADDR_STORED_DELAYS: rd_byte = stored_delays_and_comp;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  // open-drain data: the pin is only ever pulled low, sda_out stays zero
  always @(posedge clk_sys) begin
    if (reset) begin
      state <= S_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      read_mode <= 1'b0;
      ack_kind <= ACK_ADDR;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (bus_start) begin
      state <= S_ADDR;
      bit_cnt <= 3'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state <= S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        S_ADDR: begin
          if (scl_rise) begin
            shift <= rx_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              if (rx_next[7:1] == DEVICE_ADDR) begin
                read_mode <= rx_next[0];
                ack_kind <= ACK_ADDR;
                state <= S_ACK_WAIT;
              end else begin
                state <= S_IDLE;
              end
            end
          end
        end
        S_PTR: begin
          if (scl_rise) begin
            shift <= rx_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_end) begin
              ptr <= rx_next;
              ack_kind <= ACK_PTR;
              state <= S_ACK_WAIT;
            end
          end
        end
        S_WDATA: begin
          if (scl_rise) begin
            shift <= rx_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_end) begin
              ptr <= ptr + 8'h01;
              ack_kind <= ACK_DATA;
              state <= S_ACK_WAIT;
            end
          end
        end
        S_ACK_WAIT: begin
          if (scl_fall) begin
            sda_oe <= 1'b1;
            state <= S_ACK_HOLD;
          end
        end
        S_ACK_HOLD: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if ((ack_kind == ACK_ADDR) && read_mode) begin
              sda_oe <= ~rd_byte[7];
              tx <= {rd_byte[6:0], 1'b0};
              state <= S_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= (ack_kind == ACK_ADDR) ? S_PTR : S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              state <= S_RACK_WAIT;
            end
          end else if (scl_fall) begin
            sda_oe <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end
        S_RACK_WAIT: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= S_RACK;
          end
        end
        S_RACK: begin
          // a master nack ends the read; we then wait for stop
          if (scl_rise) begin
            if (!sda_q) begin
              ptr <= ptr + 8'h01;
              state <= S_RLOAD;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_RLOAD: begin
          if (scl_fall) begin
            sda_oe <= ~rd_byte[7];
            tx <= {rd_byte[6:0], 1'b0};
            bit_cnt <= 3'h0;
            state <= S_RDATA;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // stored contents and reload
  // ----------------------------------------
  assign nv_capture = load_pending | reload_tick;

  // the once-a-second tick only runs while the stored reload bit is set
  always @(posedge clk_sys) begin
    if (reset) begin
      reload_cnt <= 32'h00000000;
      reload_tick <= 1'b0;
    end else if (!stored_config[`NVCS_CFG_RELOAD]) begin
      reload_cnt <= 32'h00000000;
      reload_tick <= 1'b0;
    end else if (reload_cnt == RELOAD_CYCLES - 32'h00000001) begin
      reload_cnt <= 32'h00000000;
      reload_tick <= 1'b1;
    end else begin
      reload_cnt <= reload_cnt + 32'h00000001;
      reload_tick <= 1'b0;
    end
  end

  // memory words are caught one cycle after reset release, never under reset
  always @(posedge clk_sys) begin
    if (reset) begin
      load_pending <= 1'b1;
      stored_config <= `NVCS_RST_STORED;
      stored_delays_and_comp <= `NVCS_RST_STORED;
    end else begin
      load_pending <= 1'b0;
      if (nv_capture) begin
        stored_config <= stored_config_word;
        stored_delays_and_comp <= nv_delay_word;
      end
    end
  end

  // a host write in the reload cycle wins, so a fresh setting is not lost
  always @(posedge clk_sys) begin
    if (reset) begin
      negative_gate_level <= `NVCS_RST_GATE_LEVEL;
    end else if (wr_gate_hit) begin
      negative_gate_level <= rx_next[`NVCS_GATE_MSB:`NVCS_GATE_LSB];
    end else if (nv_capture) begin
      negative_gate_level <= nv_gate_level_word;
    end
  end

  // ----------------------------------------
  // decoded outputs
  // ----------------------------------------
  assign stored_onchip_temp_select = stored_config[`NVCS_CFG_ONCHIP_TEMP];
  assign stored_periodic_reload = stored_config[`NVCS_CFG_RELOAD];
  assign stored_spread_enable = stored_config[`NVCS_CFG_SPREAD];
  assign stored_switch_freq_select = stored_config[`NVCS_CFG_FSW];
  assign stored_fault_restart_a = stored_config[`NVCS_CFG_RESTART_A_MSB:`NVCS_CFG_RESTART_A_LSB];
  assign stored_fault_restart_b = stored_config[`NVCS_CFG_RESTART_B_MSB:`NVCS_CFG_RESTART_B_LSB];
  assign stored_startup_gap_one = stored_delays_and_comp[`NVCS_DLY_T1_MSB:`NVCS_DLY_T1_LSB];
  assign stored_startup_gap_two = stored_delays_and_comp[`NVCS_DLY_T2_MSB:`NVCS_DLY_T2_LSB];
  assign stored_startup_gap_three = stored_delays_and_comp[`NVCS_DLY_T3_MSB:`NVCS_DLY_T3_LSB];
  assign stored_thermal_comp_enable = stored_delays_and_comp[`NVCS_DLY_COMP];
  assign stored_common_level_lsb = stored_delays_and_comp[`NVCS_DLY_LEVEL_LSB];

  // magnitude in millivolts lags the code by one cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      negative_gate_rail <= `NVCS_RST_GATE_LEVEL;
      negative_gate_mv <= `NVCS_GATE_BASE_MV;
      switch_freq_khz <= `NVCS_FSW_HIGH_KHZ;
    end else begin
      negative_gate_rail <= negative_gate_level;
      negative_gate_mv <= `NVCS_GATE_BASE_MV + (`NVCS_GATE_STEP_MV * {9'h000, negative_gate_level});
      switch_freq_khz <= stored_config[`NVCS_CFG_FSW] ? `NVCS_FSW_LOW_KHZ : `NVCS_FSW_HIGH_KHZ;
    end
  end

  // ----------------------------------------
  // start-up sequencer
  // ----------------------------------------
  nvcs_gap_timer #(
    .STEP_CYCLES(GAP_STEP_CYCLES)
  ) u_gap_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(gap_start),
    .code(gap_code),
    .done(gap_done)
  );

  // gaps run once after the first load; later reloads do not restart them
  always @(posedge clk_sys) begin
    if (reset) begin
      seq_state <= Q_WAIT;
      gap_start <= 1'b0;
      gap_code <= 2'h0;
      startup_stage_done <= 3'h0;
    end else begin
      gap_start <= 1'b0;
      case (seq_state)
        Q_WAIT: begin
          if (!load_pending) begin
            gap_code <= stored_delays_and_comp[`NVCS_DLY_T1_MSB:`NVCS_DLY_T1_LSB];
            gap_start <= 1'b1;
            seq_state <= Q_GAP_ONE;
          end
        end
        Q_GAP_ONE: begin
          if (gap_done) begin
            startup_stage_done[0] <= 1'b1;
            gap_code <= stored_delays_and_comp[`NVCS_DLY_T2_MSB:`NVCS_DLY_T2_LSB];
            gap_start <= 1'b1;
            seq_state <= Q_GAP_TWO;
          end
        end
        Q_GAP_TWO: begin
          if (gap_done) begin
            startup_stage_done[1] <= 1'b1;
            gap_code <= stored_delays_and_comp[`NVCS_DLY_T3_MSB:`NVCS_DLY_T3_LSB];
            gap_start <= 1'b1;
            seq_state <= Q_GAP_THREE;
          end
        end
        Q_GAP_THREE: begin
          if (gap_done) begin
            startup_stage_done[2] <= 1'b1;
            seq_state <= Q_DONE;
          end
        end
        Q_DONE: begin
          seq_state <= Q_DONE;
        end
        default: begin
          seq_state <= Q_WAIT;
        end
      endcase
    end
  end

endmodule

// >>> test/nvcs_regs_checker.sv
`timescale 1ns/100ps

module nvcs_regs_checker (
  input wire clk_sys,
  input wire reset,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [7:0] stored_config_word,
  input wire [7:0] nv_delay_word,
  input wire [5:0] negative_gate_rail,
  input wire [14:0] negative_gate_mv,
  input wire stored_onchip_temp_select,
  input wire stored_periodic_reload,
  input wire stored_spread_enable,
  input wire stored_switch_freq_select,
  input wire [1:0] stored_fault_restart_a,
  input wire [1:0] stored_fault_restart_b,
  input wire [1:0] stored_startup_gap_one,
  input wire [1:0] stored_startup_gap_two,
  input wire [1:0] stored_startup_gap_three,
  input wire stored_thermal_comp_enable,
  input wire stored_common_level_lsb,
  input wire [11:0] switch_freq_khz,
  input wire [2:0] startup_stage_done
);
  // stored fields packed back into their register images
  wire [7:0] cfg_seen = {stored_onchip_temp_select, stored_periodic_reload, stored_spread_enable,
    stored_switch_freq_select, stored_fault_restart_a, stored_fault_restart_b};
  wire [7:0] dly_seen = {stored_startup_gap_one, stored_startup_gap_two, stored_startup_gap_three,
    stored_thermal_comp_enable, stored_common_level_lsb};

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // past values are only trusted once the cycle before was out of reset
  sequence s_running;
    !$past(reset);
  endsequence
  // the first capture after reset is a load, not a reload, so skip two cycles
  sequence s_reload_idle;
    !$past(reset) && !$past(reset, 2) && !$past(stored_periodic_reload);
  endsequence
  // an ack or data bit stands from one scl fall to the next, far longer than 8 clocks
  sequence s_drive_hold;
    sda_oe [*7];
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("sda_out left low level");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved while scl high");
  a_drive_holds: assert property ($rose(sda_oe) |=> s_drive_hold)
    else $error("sda_oe dropped too soon");
  a_mv_tracks_rail: assert property (s_running |-> negative_gate_mv == 15'h15E0 + 15'h00C8 * negative_gate_rail)
    else $error("gate millivolts do not match code");
  a_fsw_tracks_bit: assert property (s_running |-> switch_freq_khz == ($past(stored_switch_freq_select) ? 12'h1B8 : 12'h898))
    else $error("switch frequency does not match select bit");
  a_cfg_from_memory: assert property ($changed(cfg_seen) |-> cfg_seen == $past(stored_config_word))
    else $error("stored config changed to a value not from memory");
  a_dly_from_memory: assert property ($changed(dly_seen) |-> dly_seen == $past(nv_delay_word))
    else $error("stored delays changed to a value not from memory");
  a_reload_off_hold: assert property (s_reload_idle |-> $stable(cfg_seen) && $stable(dly_seen))
    else $error("stored registers reloaded with reload off");
  a_stage_in_order: assert property (startup_stage_done inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("start-up stages out of order");
  a_stage_sticky: assert property (s_running |-> (startup_stage_done & $past(startup_stage_done)) == $past(startup_stage_done))
    else $error("start-up stage bit cleared");
endmodule

bind nvcs_regs nvcs_regs_checker u_nvcs_chk (.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .stored_config_word(stored_config_word), .nv_delay_word(nv_delay_word),
  .negative_gate_rail(negative_gate_rail), .negative_gate_mv(negative_gate_mv),
  .stored_onchip_temp_select(stored_onchip_temp_select), .stored_periodic_reload(stored_periodic_reload),
  .stored_spread_enable(stored_spread_enable), .stored_switch_freq_select(stored_switch_freq_select),
  .stored_fault_restart_a(stored_fault_restart_a), .stored_fault_restart_b(stored_fault_restart_b),
  .stored_startup_gap_one(stored_startup_gap_one), .stored_startup_gap_two(stored_startup_gap_two),
  .stored_startup_gap_three(stored_startup_gap_three), .stored_thermal_comp_enable(stored_thermal_comp_enable),
  .stored_common_level_lsb(stored_common_level_lsb), .switch_freq_khz(switch_freq_khz),
  .startup_stage_done(startup_stage_done));

// >>> test/tb_nvcs_regs.sv
`timescale 1ns/100ps

module tb_nvcs_regs;
  localparam [6:0] DEV = 7'h2A;
  logic clk_sys;
  logic reset = 1'b1;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic [7:0] cfg_w = 8'hB6;
  logic [7:0] dly_w = 8'hDB;
  logic [5:0] gate_w = 6'h2A;
  wire sda_out, sda_oe, t_sel, t_rel, t_ss, t_fsw, t_comp, t_lsb;
  wire [1:0] t_ra, t_rb, t_g1, t_g2, t_g3;
  wire [5:0] rail;
  wire [14:0] mv;
  wire [11:0] khz;
  wire [2:0] stage;
  // open-drain line with pull-up: low whenever anyone pulls
  wire sda_wire = sda_oe ? 1'b0 : sda_m;
  wire [7:0] cfg_seen = {t_sel, t_rel, t_ss, t_fsw, t_ra, t_rb};
  wire [7:0] dly_seen = {t_g1, t_g2, t_g3, t_comp, t_lsb};
  int bad_count = 0;
  int checks_done = 0;
  logic [5:0] codes [3] = '{6'h00, 6'h3F, 6'h15};

  // short gap and reload counts keep the run small
  nvcs_regs #(.DEVICE_ADDR(DEV), .GAP_STEP_CYCLES(32'h0000000A), .RELOAD_CYCLES(32'h00000032)) dut (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_m), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .stored_config_word(cfg_w), .nv_delay_word(dly_w), .nv_gate_level_word(gate_w),
    .negative_gate_rail(rail), .negative_gate_mv(mv), .stored_onchip_temp_select(t_sel),
    .stored_periodic_reload(t_rel), .stored_spread_enable(t_ss), .stored_switch_freq_select(t_fsw),
    .stored_fault_restart_a(t_ra), .stored_fault_restart_b(t_rb), .stored_startup_gap_one(t_g1),
    .stored_startup_gap_two(t_g2), .stored_startup_gap_three(t_g3), .stored_thermal_comp_enable(t_comp),
    .stored_common_level_lsb(t_lsb), .switch_freq_khz(khz), .startup_stage_done(stage));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // serial host tasks
  // ----------------------------------------
  task wclk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one scl pulse; half periods of 12 clocks stay above the filter's need
  task bit_io(input logic b, output logic s);
    wclk(4); sda_m <= b;
    wclk(8); scl_m <= 1'b1;
    wclk(6); s = sda_wire;
    wclk(6); scl_m <= 1'b0;
  endtask

  task send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    check_val("ack", 16'h0000, {15'h0000, s});
  endtask

  task start_cond;
    wclk(6); sda_m <= 1'b1;
    wclk(6); scl_m <= 1'b1;
    wclk(12); sda_m <= 1'b0;
    wclk(12); scl_m <= 1'b0;
  endtask

  task stop_cond;
    wclk(6); sda_m <= 1'b0;
    wclk(6); scl_m <= 1'b1;
    wclk(12); sda_m <= 1'b1;
    wclk(12);
  endtask

  task reg_write(input logic [7:0] p, input logic [7:0] d);
    start_cond; send_byte({DEV, 1'b0}); send_byte(p); send_byte(d); stop_cond;
  endtask

  // pointer set by a write, then repeated start and one byte ended by nack
  task read_check(input string what, input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] v;
    logic s;
    start_cond; send_byte({DEV, 1'b0}); send_byte(p);
    start_cond; send_byte({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, s);
    stop_cond;
    check_val(what, {8'h00, exp}, {8'h00, v});
  endtask

  task print_verdict;
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    wclk(12);
    check_val("rail reset", 16'h0016, rail);
    check_val("khz reset", 16'h0898, khz);
    reset <= 1'b0;
    wclk(20);
    // gap one is 3 steps of 10, so nothing may be done yet
    check_val("stage early", 16'h0000, stage);
    check_val("config image", 16'h00B6, cfg_seen);
    check_val("delay image", 16'h00DB, dly_seen);
    check_val("rail captured", 16'h002A, rail);
    check_val("mv captured", 16'h36B0, mv);
    check_val("khz low", 16'h01B8, khz);
    for (int n = 0; n < 300 && stage !== 3'h7; n++) wclk(1);
    check_val("stage all", 16'h0007, stage);
    foreach (codes[k]) begin
      reg_write(8'h15, {2'b11, codes[k]});
      wclk(3);
      check_val("rail written", codes[k], rail);
      check_val("mv written", 16'h15E0 + 16'h00C8 * codes[k], mv);
      read_check("gate readback", 8'h15, {2'b00, codes[k]});
    end
    reg_write(8'h17, 8'h00);
    reg_write(8'h18, 8'h00);
    check_val("config kept", 16'h00B6, cfg_seen);
    check_val("delay kept", 16'h00DB, dly_seen);
    read_check("config read", 8'h17, 8'hB6);
    read_check("delay read", 8'h18, 8'hDB);
    read_check("unmapped read", 8'h30, 8'h00);
    // reload bit clear: new memory contents must not appear
    cfg_w <= 8'h49;
    gate_w <= 6'h01;
    wclk(150);
    check_val("config no reload", 16'h00B6, cfg_seen);
    check_val("rail no reload", 16'h0015, rail);
    // second reset with reload bit set, then memory changes under it
    reset <= 1'b1;
    cfg_w <= 8'h45;
    dly_w <= 8'h00;
    wclk(12);
    reset <= 1'b0;
    wclk(5);
    check_val("config second", 16'h0045, cfg_seen);
    check_val("khz high", 16'h0898, khz);
    cfg_w <= 8'h5A;
    gate_w <= 6'h07;
    wclk(120);
    check_val("config reloaded", 16'h005A, cfg_seen);
    check_val("rail reloaded", 16'h0007, rail);
    check_val("khz reloaded", 16'h01B8, khz);
    print_verdict;
  end

  // the sequence above needs about 10000 clocks
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    print_verdict;
  end
endmodule
